// *** cadc_top.sv ***
`timescale 1ns/1ps
`include "cadc_regs.svh"
// Comparator and reference ladder control, Wishbone classic slave
module cadc_top
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  raw_cmp,
  input  wire logic        tmr_clk,
  input  wire logic [1:0]  pin_direction,
  input  wire logic [1:0]  port_latch,
  output logic [1:0]       cmp_pin_out,
  output logic [1:0]       cmp_pin_oe_b,
  output logic [1:0]       cmp_gate,
  output logic [1:0]       cmp_irq_flag,
  output logic [1:0]       cmp_enable,
  output logic [1:0]       cmp_speed_power,
  output logic [1:0]       cmp_hysteresis_en,
  output logic             ladder_enable,
  output logic             ladder_pin_output_enable,
  output logic [1:0]       positive_source_sel,
  output logic             negative_source_sel,
  output logic [4:0]       ladder_level_code,
  output cadc_pkg::cadc_lad_state_t ladder_state
);
  import cadc_pkg::*;

  logic [7:0]      ladder_control_0;
  logic [7:0]      ladder_level_select;
  logic [7:0]      con0 [2];
  logic [7:0]      con1 [2];
  logic [1:0]      res;
  logic [1:0]      gate;
  logic [1:0]      flag;
  logic [1:0]      flag_clr;
  logic [1:0]      dir_s1;
  logic [1:0]      dir_s2;
  logic [1:0]      lat_s1;
  logic [1:0]      lat_s2;
  logic            req;
  logic            wr;
  logic [3:0]      idx;
  logic [7:0]      wbyte;
  logic [7:0]      rbyte;
  cadc_lad_state_t next_ladder_state;

  // One-cycle answer: ack rises the edge after the request, then drops
  // Writes land on the edge where the master samples ack high
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign idx   = wb_adr_i[5:2];
  assign wbyte = wb_dat_i[7:0];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Ladder registers: reset clears all; sleep has no path here
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ladder_control_0    <= 8'h00;
      ladder_level_select <= 8'h00;
    end else if (wr && idx == `CADC_ADR_LAD0) begin
      // Reserved source code kept out by software
      ladder_control_0 <= wbyte & `CADC_LAD0_MASK;
    end else if (wr && idx == `CADC_ADR_LAD1) begin
      ladder_level_select <= wbyte & `CADC_LAD1_MASK;
    end
  end

  // Comparator control registers; speed bit resets high
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      con0[0] <= `CADC_CON0_RST;
      con0[1] <= `CADC_CON0_RST;
      con1[0] <= 8'h00;
      con1[1] <= 8'h00;
    end else if (wr) begin
      if (idx == `CADC_ADR_C1CON0) begin
        con0[0] <= wbyte & `CADC_CON0_MASK;
      end
      if (idx == `CADC_ADR_C2CON0) begin
        con0[1] <= wbyte & `CADC_CON0_MASK;
      end
      if (idx == `CADC_ADR_C1CON1) begin
        con1[0] <= wbyte & `CADC_CON1_MASK;
      end
      if (idx == `CADC_ADR_C2CON1) begin
        con1[1] <= wbyte & `CADC_CON1_MASK;
      end
    end
  end

  // Write-one-to-clear for the sticky flags
  assign flag_clr = (wr && idx == `CADC_ADR_IRQ) ? wbyte[1:0] : 2'h0;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cmp
      cadc_cmp_chan u_chan (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .raw_cmp  (raw_cmp[g]),
        .tmr_clk  (tmr_clk),
        .con0     (con0[g]),
        .con1     (con1[g]),
        .flag_clr (flag_clr[g]),
        .result   (res[g]),
        .gate_out (gate[g]),
        .irq_flag (flag[g])
      );
    end
  endgenerate

  // Read mux; result visible in both places
  always_comb begin
    rbyte = 8'h00;
    unique case (idx)
      `CADC_ADR_LAD0:   rbyte = ladder_control_0;
      `CADC_ADR_LAD1:   rbyte = ladder_level_select;
      `CADC_ADR_C1CON0: rbyte = con0[0] | {1'b0, res[0], 6'h00};
      `CADC_ADR_C2CON0: rbyte = con0[1] | {1'b0, res[1], 6'h00};
      `CADC_ADR_C1CON1: rbyte = con1[0];
      `CADC_ADR_C2CON1: rbyte = con1[1];
      `CADC_ADR_CMP_SHARED_RESULT_REG:  rbyte = {6'h00, res};
      `CADC_ADR_IRQ:    rbyte = {6'h00, flag};
      default:          rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rbyte};
    end
  end

  // Pin-side inputs come from the port block's own domain, synchronise
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dir_s1 <= 2'h3;
      dir_s2 <= 2'h3;
      lat_s1 <= 2'h0;
      lat_s2 <= 2'h0;
    end else begin
      dir_s1 <= pin_direction;
      dir_s2 <= dir_s1;
      lat_s1 <= port_latch;
      lat_s2 <= lat_s1;
    end
  end

  // Pin override and drive
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_pin_out  <= 2'h0;
      cmp_pin_oe_b <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cmp_pin_out[i] <= con0[i][`CADC_B_OE] ? gate[i] : lat_s2[i];
        cmp_pin_oe_b[i] <= ~(con0[i][`CADC_B_OE] & ~dir_s2[i]
                             & con0[i][`CADC_B_EN]);
      end
    end
  end

  // Analog control outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_gate          <= 2'h0;
      cmp_irq_flag      <= 2'h0;
      cmp_enable        <= 2'h0;
      cmp_speed_power   <= 2'h3;
      cmp_hysteresis_en <= 2'h0;
    end else begin
      cmp_gate     <= gate;
      cmp_irq_flag <= flag;
      for (int i = 0; i < 2; i++) begin
        cmp_enable[i]        <= con0[i][`CADC_B_EN];
        cmp_speed_power[i]   <= con0[i][`CADC_B_SP];
        cmp_hysteresis_en[i] <= con0[i][`CADC_B_HYS];
      end
    end
  end

  // Ladder low-power clamp decode
  always_comb begin
    next_ladder_state = CADC_LAD_IDLE;
    if (ladder_control_0[`CADC_B_EN]) begin
      next_ladder_state = CADC_LAD_ACTIVE;
    end else if (ladder_control_0[`CADC_B_LPS] &&
                 ladder_level_select[4:0] == `CADC_CODE_ONES) begin
      next_ladder_state = CADC_LAD_CLAMP_POS;
    end else if (!ladder_control_0[`CADC_B_LPS] &&
                 ladder_level_select[4:0] == `CADC_CODE_ZERO) begin
      next_ladder_state = CADC_LAD_CLAMP_NEG;
    end
  end

  // Ladder analog controls
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ladder_enable            <= 1'b0;
      ladder_pin_output_enable <= 1'b0;
      positive_source_sel      <= 2'h0;
      negative_source_sel      <= 1'b0;
      ladder_level_code        <= 5'h00;
      ladder_state             <= CADC_LAD_IDLE;
    end else begin
      ladder_enable            <= ladder_control_0[`CADC_B_EN];
      ladder_pin_output_enable <= ladder_control_0[`CADC_B_OE];
      positive_source_sel      <= ladder_control_0[3:2];
      negative_source_sel      <= ladder_control_0[0];
      ladder_level_code        <= ladder_level_select[4:0];
      ladder_state             <= next_ladder_state;
    end
  end

  // All checks run on the bus clock and stand down during reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // A ladder write lands, then the analog copy follows an edge later
  sequence s_lad0_write;
    wr && idx == `CADC_ADR_LAD0;
  endsequence

  sequence s_lad0_copied;
    ##2 ladder_enable == $past(wbyte[`CADC_B_EN], 2);
  endsequence

  // Reads are taken on the request edge and answered one edge later
  sequence s_cmp_shared_result_reg_read;
    req && !wb_we_i && idx == `CADC_ADR_CMP_SHARED_RESULT_REG;
  endsequence

  sequence s_c1_read;
    req && !wb_we_i && idx == `CADC_ADR_C1CON0;
  endsequence

  // Answer is one pulse; a stretched ack would double the transfer
  AST_ACK_ONE_CYCLE: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("ack not single cycle");

  // No ack without a request in front of it
  AST_ACK_NEEDS_REQ: assert property (
    !req |=> !wb_ack_o
  ) else $error("ack without request");

  // Nothing but a bus write may touch control 0, sleep included
  AST_LAD0_HOLDS: assert property (
    !(wr && idx == `CADC_ADR_LAD0) |=> $stable(ladder_control_0)
  ) else $error("ladder control changed without write");

  // Enable bit reaches the ladder two edges after the write
  AST_LAD_ENABLE: assert property (
    s_lad0_write |-> s_lad0_copied
  ) else $error("enable not applied");

  AST_LAD_PIN_COPY: assert property (
    rst_b |=> ladder_pin_output_enable
              == $past(ladder_control_0[`CADC_B_OE])
  ) else $error("pin routing not applied");

  AST_LAD_SRC_COPY: assert property (
    rst_b |=> positive_source_sel
              == $past(ladder_control_0[`CADC_B_PSS_HI:`CADC_B_PSS_LO])
              && negative_source_sel
              == $past(ladder_control_0[`CADC_B_NSS])
  ) else $error("source select not applied");

  AST_LEVEL_COPY: assert property (
    rst_b |=> ladder_level_code
              == $past(ladder_level_select[`CADC_CODE_HI:0])
  ) else $error("level code not applied");

  // Only the five code bits of the level register can be written
  AST_LEVEL_MASKED: assert property (
    (wr && idx == `CADC_ADR_LAD1)
    |=> ladder_level_select == ($past(wbyte) & `CADC_LAD1_MASK)
  ) else $error("level write not masked");

  // Clamp states need the ladder off and the matching end code
  AST_CLAMP_POS: assert property (
    (rst_b && !ladder_control_0[`CADC_B_EN]
     && ladder_control_0[`CADC_B_LPS]
     && ladder_level_select[`CADC_CODE_HI:0] == `CADC_CODE_ONES)
    |=> ladder_state == CADC_LAD_CLAMP_POS
  ) else $error("positive clamp missing");

  AST_CLAMP_NEG: assert property (
    (rst_b && !ladder_control_0[`CADC_B_EN]
     && !ladder_control_0[`CADC_B_LPS]
     && ladder_level_select[`CADC_CODE_HI:0] == `CADC_CODE_ZERO)
    |=> ladder_state == CADC_LAD_CLAMP_NEG
  ) else $error("negative clamp missing");

  // Unimplemented bits are masked on write and never read back set
  AST_RSVD_ZERO: assert property (
    (ladder_control_0 & ~`CADC_LAD0_MASK) == 8'h00
    && (ladder_level_select & ~`CADC_LAD1_MASK) == 8'h00
  ) else $error("reserved bits set");

  // Pin drive needs pin enable, direction clear and comparator on
  AST_PIN_DRIVE: assert property (
    !cmp_pin_oe_b[0] |-> $past(con0[0][`CADC_B_EN])
                         && $past(con0[0][`CADC_B_OE])
                         && !$past(dir_s2[0])
  ) else $error("pin driven without enables");

  // Pin enable alone picks the source; comparator enable plays no part
  AST_PIN_OVERRIDE: assert property (
    rst_b |=> cmp_pin_out[0] == ($past(con0[0][`CADC_B_OE])
                                 ? $past(gate[0]) : $past(lat_s2[0]))
  ) else $error("pin source wrong");

  AST_SHARED_RES: assert property (
    s_cmp_shared_result_reg_read |=> wb_dat_o[1:0] == $past(res)
  ) else $error("shared result mismatch");

  AST_OWN_RESULT: assert property (
    s_c1_read |=> wb_dat_o[`CADC_B_OUT] == $past(res[0])
  ) else $error("own result bit mismatch");

  // Analog control copies trail their register bits by one edge
  AST_EN_COPY: assert property (
    rst_b |=> cmp_enable[0] == $past(con0[0][`CADC_B_EN])
              && cmp_enable[1] == $past(con0[1][`CADC_B_EN])
  ) else $error("comparator enable not applied");

  AST_SPEED_COPY: assert property (
    rst_b |=> cmp_speed_power[0] == $past(con0[0][`CADC_B_SP])
              && cmp_speed_power[1] == $past(con0[1][`CADC_B_SP])
  ) else $error("speed select not applied");

  AST_HYS_COPY: assert property (
    rst_b |=> cmp_hysteresis_en[0] == $past(con0[0][`CADC_B_HYS])
              && cmp_hysteresis_en[1] == $past(con0[1][`CADC_B_HYS])
  ) else $error("hysteresis not applied");

  AST_GATE_COPY: assert property (
    rst_b |=> cmp_gate == $past(gate)
  ) else $error("gate source not forwarded");

  AST_FLAG_COPY: assert property (
    rst_b |=> cmp_irq_flag == $past(flag)
  ) else $error("flag not forwarded");
endmodule : cadc_top

// *** cadc_regs.svh ***
`ifndef CADC_REGS_SVH
`define CADC_REGS_SVH
// Summary of operation
// - Ladder off, keep-positive set, code all ones: output held at positive source.
// - Ladder off, keep-positive clear, code all zeros: output held at negative source.
// - Waking from sleep leaves ladder control register 0 unchanged.
// - Reset disables ladder, removes pin output, clears level code.
// - Control 0 bit 7 enables the ladder; resets to zero.
// - Control 0 bit 6 picks which source stays connected in low power.
// - Control 0 bit 5 routes ladder voltage to its output pin.
// - Bits 3-2 pick positive source; code 11 reserved, never written.
// - Control 0 bit 0 picks negative source: external pin or ground.
// - Level code in bits 4-0; unused bits read as zero.
// - Raw result high when non-inverting input above inverting input.
// - Comparator enable starts it; clearing puts it in lowest current.
// - Result readable in own control register and shared result register.
// - Pin driven only with pin enable, direction clear, comparator enabled.
// - Pin enable overrides port latch regardless of comparator enable.
// - Internal result registered each cycle; pin unlatched unless sync chosen.
// - Invert bit inverts reported result; clear passes raw result.
// - Speed/power bit resets to one (normal); zero selects low power.
// - Hysteresis bit switches comparator input hysteresis on or off.
// - Result offered as timer gate source; sync recommended.
// - Sync captures result on falling edge of timer source clock.
// - Enabled rising or falling result edges set the sticky irq flag.
// - Edge during flag clear leaves the flag set.
// - Disabled comparator disconnects inputs; polarity/enable change may still flag.
`define CADC_ADR_LAD0    4'h0
`define CADC_ADR_LAD1    4'h1
`define CADC_ADR_C1CON0  4'h2
`define CADC_ADR_C1CON1  4'h3
`define CADC_ADR_C2CON0  4'h4
`define CADC_ADR_C2CON1  4'h5
`define CADC_ADR_CMP_SHARED_RESULT_REG   4'h6
`define CADC_ADR_IRQ     4'h7
`define CADC_LAD0_MASK   8'hED
`define CADC_LAD1_MASK   8'h1F
`define CADC_CON0_MASK   8'hB7
`define CADC_CON0_RST    8'h04
`define CADC_CON1_MASK   8'hF3
`define CADC_CODE_ONES   5'h1F
`define CADC_CODE_ZERO   5'h00
`define CADC_B_EN        7
`define CADC_B_OUT       6
`define CADC_B_OE        5
`define CADC_B_POL       4
`define CADC_B_SP        2
`define CADC_B_HYS       1
`define CADC_B_SYNC      0
`define CADC_B_INTP      7
`define CADC_B_INTN      6
`define CADC_B_LPS       6
`define CADC_B_PSS_HI    3
`define CADC_B_PSS_LO    2
`define CADC_B_NSS       0
`define CADC_CODE_HI     4
`endif

// *** cadc_pkg.sv ***
package cadc_pkg;
  typedef enum logic [1:0] {
    CADC_PSRC_SUPPLY,
    CADC_PSRC_EXT_PIN,
    CADC_PSRC_FIXED_BUF2,
    CADC_PSRC_RESERVED
  } cadc_psrc_t;
  typedef enum logic [1:0] {
    CADC_LAD_ACTIVE,
    CADC_LAD_CLAMP_POS,
    CADC_LAD_CLAMP_NEG,
    CADC_LAD_IDLE
  } cadc_lad_state_t;
endpackage : cadc_pkg

// *** cadc_cmp_chan.sv ***
`timescale 1ns/1ps
`include "cadc_regs.svh"
// One comparator channel: sync, polarity, timer-sync latch, edge flag
module cadc_cmp_chan (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       raw_cmp,
  input  wire logic       tmr_clk,
  input  wire logic [7:0] con0,
  input  wire logic [7:0] con1,
  input  wire logic       flag_clr,
  output logic            result,
  output logic            gate_out,
  output logic            irq_flag
);
  logic raw_s1;
  logic raw_s2;
  logic tmr_s1;
  logic tmr_s2;
  logic tmr_d;
  logic sync_q;
  logic prev_res;
  logic next_res;
  logic rise;
  logic fall;

  // Two stages: front end output is asynchronous
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      raw_s1 <= 1'b0;
      raw_s2 <= 1'b0;
      tmr_s1 <= 1'b0;
      tmr_s2 <= 1'b0;
    end else begin
      raw_s1 <= raw_cmp;
      raw_s2 <= raw_s1;
      tmr_s1 <= tmr_clk;
      tmr_s2 <= tmr_s1;
    end
  end

  // Disabled comparator reports the polarity bit, inputs disconnected
  // Polarity applied after the enable gate, so toggling either can flag
  always_comb begin
    next_res = (con0[`CADC_B_EN] & raw_s2) ^ con0[`CADC_B_POL];
  end

  // Internal result latched every cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      result   <= 1'b0;
      prev_res <= 1'b0;
      tmr_d    <= 1'b0;
    end else begin
      result   <= next_res;
      prev_res <= result;
      tmr_d    <= tmr_s2;
    end
  end

  // Capture on every falling timer clock edge; gate takes it when sync selected
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= 1'b0;
    end else if (tmr_d && !tmr_s2) begin
      sync_q <= result;
    end
  end

  // Gate source for the timer and pin path
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gate_out <= 1'b0;
    end else begin
      gate_out <= con0[`CADC_B_SYNC] ? sync_q : next_res;
    end
  end

  assign rise = result & ~prev_res;
  assign fall = ~result & prev_res;

  // Sticky flag; a new edge wins over the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag <= 1'b0;
    end else if ((rise && con1[`CADC_B_INTP]) ||
                 (fall && con1[`CADC_B_INTN])) begin
      irq_flag <= 1'b1;
    end else if (flag_clr) begin
      irq_flag <= 1'b0;
    end
  end

  // Checks run on the channel clock and stand down during reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // An enabled rising edge sets the flag on the next edge
  AST_EDGE_SETS_FLAG: assert property (
    (rise && con1[`CADC_B_INTP]) |=> irq_flag
  ) else $error("rising edge did not set flag");

  AST_SET_BEATS_CLEAR: assert property (
    (fall && con1[`CADC_B_INTN] && flag_clr) |=> irq_flag
  ) else $error("flag lost to clear");

  // Sampled reset keeps the release edge out of the antecedent
  AST_POLARITY: assert property (
    rst_b |=> result == (($past(con0[`CADC_B_EN]) & $past(raw_s2))
                         ^ $past(con0[`CADC_B_POL]))
  ) else $error("polarity wrong");
endmodule : cadc_cmp_chan

// *** cadc_afe_model.sv ***
`timescale 1ns/1ps
// Stand-in for the analog comparators and the timer clock source
module cadc_afe_model (
  output logic [1:0] raw_cmp,
  output logic       tmr_clk
);
  // Both comparators start with the inverting input on top
  initial begin
    raw_cmp = 2'h0;
    tmr_clk = 1'b0;
  end
  // Raw result is high only while the non-inverting input is above
  // Changes off the mclk edge, so the control side must resync it
  task automatic set_in(input int ch, input real vp, input real vn);
    #3;
    raw_cmp[ch] = (vp > vn);
  endtask : set_in
  // Timer source clock idles low and runs only when asked
  task automatic tick(input int half_ns);
    tmr_clk = 1'b1;
    #(half_ns);
    tmr_clk = 1'b0;
    #(half_ns);
  endtask : tick
endmodule : cadc_afe_model

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "cadc_regs.svh"
// Register-level bench for the comparator and ladder control block
module tb_top;
  import cadc_pkg::*;
  localparam logic [5:0] A_L0 = {`CADC_ADR_LAD0, 2'b00};
  localparam logic [5:0] A_L1 = {`CADC_ADR_LAD1, 2'b00};
  localparam logic [5:0] A_C1 = {`CADC_ADR_C1CON0, 2'b00};
  localparam logic [5:0] A_C1B = {`CADC_ADR_C1CON1, 2'b00};
  localparam logic [5:0] A_C2 = {`CADC_ADR_C2CON0, 2'b00};
  localparam logic [5:0] A_CM = {`CADC_ADR_CMP_SHARED_RESULT_REG, 2'b00};
  localparam logic [5:0] A_IRQ = {`CADC_ADR_IRQ, 2'b00};
  logic mclk = 1'b0, rst_b = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, tmr_clk, ladder_enable, ladder_pin_output_enable;
  logic negative_source_sel;
  logic [1:0] raw_cmp, pin_direction = 2'h0, port_latch = 2'h3;
  logic [1:0] cmp_pin_out, cmp_pin_oe_b, cmp_gate, cmp_irq_flag;
  logic [1:0] cmp_enable, cmp_speed_power, cmp_hysteresis_en;
  logic [1:0] positive_source_sel;
  logic [4:0] ladder_level_code;
  cadc_lad_state_t ladder_state;
  int err_count = 0, n_compared = 0;
  logic [7:0] q;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  cadc_top i_cadc_top (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .raw_cmp(raw_cmp), .tmr_clk(tmr_clk),
    .pin_direction(pin_direction), .port_latch(port_latch),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe_b(cmp_pin_oe_b),
    .cmp_gate(cmp_gate), .cmp_irq_flag(cmp_irq_flag),
    .cmp_enable(cmp_enable), .cmp_speed_power(cmp_speed_power),
    .cmp_hysteresis_en(cmp_hysteresis_en), .ladder_enable(ladder_enable),
    .ladder_pin_output_enable(ladder_pin_output_enable),
    .positive_source_sel(positive_source_sel),
    .negative_source_sel(negative_source_sel),
    .ladder_level_code(ladder_level_code), .ladder_state(ladder_state));

  cadc_afe_model i_cadc_afe_model (.raw_cmp(raw_cmp), .tmr_clk(tmr_clk));

  // Verdict, reached from the main sequence or the watchdog
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
               exp);
    end
  endtask : chk

  task automatic settle;
    repeat (8) @(posedge mclk);
  endtask : settle

  // Classic single cycle; request held until ack is sampled high
  task automatic xfer(input logic we, input logic [5:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o[7:0];
    if (n >= 50) err_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Control outputs trail the register by a cycle, so let them land
    settle();
  endtask : xfer

  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rdchk

  // Watchdog far beyond the under a thousand cycles the tests need
  initial begin
    #(25 * 40000);
    err_count++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    settle();
    chk({ladder_enable, ladder_pin_output_enable, ladder_level_code}, 0);
    chk(ladder_state, CADC_LAD_CLAMP_NEG);
    rdchk(A_L0, 8'h00);
    rdchk(A_L1, 8'h00);
    rdchk(A_C1, 8'h04);
    chk(cmp_speed_power, 2'h3);
    // Unmapped place: write dropped, read zero
    xfer(1'b1, 6'h20, 8'hFF);
    rdchk(6'h20, 8'h00);
    // Every legal positive source, with all writable bits set
    for (int s = 0; s < 3; s++) begin
      xfer(1'b1, A_L0, 8'hF3 | (s << 2));
      rdchk(A_L0, 8'hE1 | (s << 2));
      chk(positive_source_sel, s);
      chk({ladder_enable, ladder_pin_output_enable}, 2'h3);
      chk(negative_source_sel, 1'b1);
      chk(ladder_state, CADC_LAD_ACTIVE);
    end
    xfer(1'b1, A_L0, 8'h00);
    chk({ladder_enable, ladder_pin_output_enable}, 2'h0);
    chk(negative_source_sel, 1'b0);
    xfer(1'b1, A_L1, 8'hFF);
    rdchk(A_L1, 8'h1F);
    chk(ladder_level_code, 5'h1F);
    xfer(1'b1, A_L0, 8'h40);
    chk(ladder_state, CADC_LAD_CLAMP_POS);
    xfer(1'b1, A_L0, 8'h00);
    xfer(1'b1, A_L1, 8'hE0);
    chk(ladder_state, CADC_LAD_CLAMP_NEG);
    // Both comparators: result, mirror, polarity, speed and hysteresis
    for (int ch = 0; ch < 2; ch++) begin
      i_cadc_afe_model.set_in(ch, 1.0, 0.5);
      xfer(1'b1, ch ? A_C2 : A_C1, 8'h86);
      chk({cmp_enable[ch], cmp_hysteresis_en[ch]}, 2'h3);
      rdchk(ch ? A_C2 : A_C1, 8'hC6);
      rdchk(A_CM, 8'h01 << ch);
      xfer(1'b1, ch ? A_C2 : A_C1, 8'h96);
      rdchk(ch ? A_C2 : A_C1, 8'h96);
      i_cadc_afe_model.set_in(ch, 0.2, 0.5);
      settle();
      rdchk(ch ? A_C2 : A_C1, 8'hD6);
      xfer(1'b1, ch ? A_C2 : A_C1, 8'h00);
      chk({cmp_enable[ch], cmp_speed_power[ch]}, 2'h0);
      chk(cmp_hysteresis_en[ch], 1'b0);
    end
    // Pin drive needs pin enable, direction clear and comparator on
    i_cadc_afe_model.set_in(0, 1.0, 0.5);
    xfer(1'b1, A_C1, 8'hA4);
    chk({cmp_pin_oe_b[0], cmp_pin_out[0]}, 2'h1);
    pin_direction <= 2'h1;
    settle();
    chk(cmp_pin_oe_b[0], 1'b1);
    pin_direction <= 2'h0;
    xfer(1'b1, A_C1, 8'h24);
    chk({cmp_pin_oe_b[0], cmp_pin_out[0]}, 2'h2);
    xfer(1'b1, A_C1, 8'h04);
    chk(cmp_pin_out[0], 1'b1);
    // Synchronised gate moves only on a timer clock falling edge
    i_cadc_afe_model.set_in(0, 0.2, 0.5);
    xfer(1'b1, A_C1, 8'h85);
    chk(cmp_gate[0], 1'b0);
    i_cadc_afe_model.set_in(0, 1.0, 0.5);
    settle();
    chk(cmp_gate[0], 1'b0);
    rdchk(A_C1, 8'hC5);
    i_cadc_afe_model.tick(100);
    settle();
    chk(cmp_gate[0], 1'b1);
    // Edge flags: rising only, then falling only
    xfer(1'b1, A_C1, 8'h04);
    xfer(1'b1, A_C1B, 8'h80);
    xfer(1'b1, A_IRQ, 8'h03);
    rdchk(A_IRQ, 8'h00);
    xfer(1'b1, A_C1, 8'h14);
    chk(cmp_irq_flag[0], 1'b1);
    rdchk(A_IRQ, 8'h01);
    xfer(1'b1, A_C1, 8'h84);
    xfer(1'b1, A_IRQ, 8'h01);
    i_cadc_afe_model.set_in(0, 0.2, 0.5);
    settle();
    chk(cmp_irq_flag[0], 1'b0);
    i_cadc_afe_model.set_in(0, 1.0, 0.5);
    settle();
    chk(cmp_irq_flag[0], 1'b1);
    xfer(1'b1, A_C1B, 8'h40);
    xfer(1'b1, A_IRQ, 8'h01);
    i_cadc_afe_model.set_in(0, 0.2, 0.5);
    settle();
    chk(cmp_irq_flag, 2'h1);
    // Falling edge reaches the flag on the very edge the clear lands
    i_cadc_afe_model.set_in(0, 1.0, 0.5);
    settle();
    i_cadc_afe_model.set_in(0, 0.2, 0.5);
    @(posedge mclk);
    xfer(1'b1, A_IRQ, 8'h01);
    chk(cmp_irq_flag[0], 1'b1);
    end_sim();
  end
endmodule : tb_top
